//--- core/uart_modem_line_outputs.sv
// Modem line outputs for two serial channels: request-to-send and
// serial transmit levels, plus the receive input path.
// Assumes the UART core supplies modem control bits and transmit data
// on clk_i, and that pins arrive asynchronously.
// Notes on behaviour
// [R1] RTS pin low when control bit 1 set
// [R2] Reset forces RTS inactive high
// [R3] Loop with XT strap holds RTS inactive
// [R4] Loop with AT strap RTS follows bit
// [R5] Transmit line marks after reset
// [R6] Serial input pin feeds the receiver
// [R7] Strap sampled at reset selects XT/AT
// [R8] Strap captured at release, then frozen
module uart_modem_line_outputs
  import uart_modem_line_pkg::*;
#(
  parameter int NCH = `NUM_CHANNELS  // Number of serial channels
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  ce_i,
  input  wire logic                  bus_mode_strap_i,
  input  wire logic [NCH*`MCR_WIDTH-1:0] modem_ctrl_i,
  input  wire logic [NCH-1:0]        tx_active_i,
  input  wire logic [NCH-1:0]        tx_data_i,
  input  wire logic [NCH-1:0]        serial_rx_in_i,
  output logic      [NCH-1:0]        rts_n_o,
  output logic      [NCH-1:0]        serial_tx_out_o,
  output logic      [NCH-1:0]        rx_data_o,
  output logic                       xt_mode_o
);

  // Block's own registered state in one struct; the synchronisers hold theirs
  typedef struct packed {
    logic      captured;          // Strap already taken since reset
    bus_mode_t mode;              // Frozen bus mode
    logic [NCH-1:0] rts_n;        // Registered request-to-send pins
    logic [NCH-1:0] tx;           // Registered transmit pins
  } line_state_t;

  line_state_t st;
  line_state_t next_st;
  logic        strap_sync;        // Synchronised strap level
  logic [NCH-1:0] rx_sync;        // Synchronised receive pins

  // Strap is a pin, so synchronise before use. This synchroniser is kept
  // out of reset on purpose: it must keep sampling the strap while reset
  // is asserted, or the release edge would only ever see AT mode.
  pin_sync u_strap_sync (
    .clk_i    (clk_i),
    .resetn_i (1'b1),
    .ce_i     (ce_i),
    .d_i      (bus_mode_strap_i),
    .q_o      (strap_sync)
  );

  // One synchroniser per receive pin
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_rx
      pin_sync u_rx_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .d_i      (serial_rx_in_i[g]),
        .q_o      (rx_sync[g])
      );
    end
  endgenerate

  // Receiver sees the cleaned input
  assign rx_data_o = rx_sync; // R6

  // Next state: strap capture and pin levels
  always_comb begin
    logic ctl_rts;
    logic ctl_loop;
    ctl_rts  = 1'b0;
    ctl_loop = 1'b0;
    next_st  = st;
    // On the release edge the strap synchroniser still holds the level
    // the strap had late in reset; take it once, then freeze it.
    if (!st.captured) begin
      next_st.captured = 1'b1; // R8
      next_st.mode     = (strap_sync == `STRAP_XT) ? MODE_XT : MODE_AT; // R7
    end
    for (int c = 0; c < NCH; c++) begin
      ctl_rts  = modem_ctrl_i[c*`MCR_WIDTH + `MCR_RTS_BIT];
      ctl_loop = modem_ctrl_i[c*`MCR_WIDTH + `MCR_LOOP_BIT];
      // Mode being captured, so the first cycle after release is right too
      if (ctl_loop && next_st.mode == MODE_XT) begin
        next_st.rts_n[c] = `RTS_INACTIVE; // R3
      end else begin
        next_st.rts_n[c] = ~ctl_rts; // R1 R4
      end
      // Idle at mark until the transmitter starts
      next_st.tx[c] = tx_active_i[c] ? tx_data_i[c] : `TX_MARK; // R5
    end
  end

  // Register state; reset sets pins inactive and marking
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st.captured <= 1'b0;
      st.mode     <= MODE_AT;
      st.rts_n    <= {NCH{`RTS_INACTIVE}}; // R2
      st.tx       <= {NCH{`TX_MARK}}; // R5
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign rts_n_o         = st.rts_n;
  assign serial_tx_out_o = st.tx;
  assign xt_mode_o       = (st.mode == MODE_XT);

  // Checks on channel 0, reset checks on every channel, and strap handling
  property p_rts_follows;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && st.captured && !(modem_ctrl_i[`MCR_LOOP_BIT] && st.mode == MODE_XT)
      |=> rts_n_o[0] == ~$past(modem_ctrl_i[`MCR_RTS_BIT]);
  endproperty
  a_rts_follows: assert property (p_rts_follows) else $error("RTS not following bit"); // R1

  property p_reset_rts;
    @(posedge clk_i) !resetn_i |=> rts_n_o == {NCH{`RTS_INACTIVE}};
  endproperty
  a_reset_rts: assert property (p_reset_rts) else $error("RTS not high after reset"); // R2

  property p_loop_xt;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && st.captured && modem_ctrl_i[`MCR_LOOP_BIT] && st.mode == MODE_XT |=> rts_n_o[0];
  endproperty
  a_loop_xt: assert property (p_loop_xt) else $error("RTS driven in XT loop"); // R3

  property p_loop_at;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && st.captured && modem_ctrl_i[`MCR_LOOP_BIT] && st.mode == MODE_AT
      |=> rts_n_o[0] == ~$past(modem_ctrl_i[`MCR_RTS_BIT]);
  endproperty
  a_loop_at: assert property (p_loop_at) else $error("RTS wrong in AT loop"); // R4

  property p_tx_mark;
    @(posedge clk_i) !resetn_i |=> serial_tx_out_o == {NCH{`TX_MARK}};
  endproperty
  a_tx_mark: assert property (p_tx_mark) else $error("Transmit not marking"); // R5

  property p_rx_path;
    @(posedge clk_i) disable iff (!resetn_i)
      // Both stages must have shifted, out of reset, before comparing
      $past(ce_i) && $past(ce_i, 2) && $past(resetn_i) && $past(resetn_i, 2)
      |-> rx_data_o[0] == $past(serial_rx_in_i[0], 2);
  endproperty
  a_rx_path: assert property (p_rx_path) else $error("Receive path delay wrong"); // R6

  property p_mode_capture;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && !st.captured |=> xt_mode_o == $past(strap_sync);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("Strap capture wrong"); // R7

  property p_mode_frozen;
    @(posedge clk_i) disable iff (!resetn_i)
      st.captured |=> $stable(xt_mode_o);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("Bus mode changed"); // R8

  c_xt_loop: cover property (@(posedge clk_i) xt_mode_o && modem_ctrl_i[`MCR_LOOP_BIT]);
  c_at_loop: cover property (@(posedge clk_i) !xt_mode_o && modem_ctrl_i[`MCR_LOOP_BIT]);
  c_rts_on:  cover property (@(posedge clk_i) !rts_n_o[0]);
  c_tx_run:  cover property (@(posedge clk_i) tx_active_i[1] && !serial_tx_out_o[1]);
endmodule : uart_modem_line_outputs

//--- core/uart_modem_line_params.svh
// Constants for the modem line output block.
// Assumes inclusion by bare name from the package and design files.
`ifndef UART_MODEM_LINE_PARAMS_SVH
`define UART_MODEM_LINE_PARAMS_SVH
`define NUM_CHANNELS      2
`define MCR_WIDTH         8
`define MCR_RTS_BIT       1
`define MCR_LOOP_BIT      4
`define RTS_INACTIVE      1'b1
`define TX_MARK           1'b1
`define STRAP_XT          1'b1
`endif

//--- core/uart_modem_line_pkg.sv
// Types shared by the modem line output block.
// Assumes the params header is on the include path.
`include "uart_modem_line_params.svh"
package uart_modem_line_pkg;
  // Bus mode captured from the strap
  typedef enum logic [0:0] {
    MODE_AT = 1'b0,
    MODE_XT = 1'b1
  } bus_mode_t;
endpackage : uart_modem_line_pkg

//--- core/pin_sync.sv
// Two flip-flop synchroniser for one pin.
// Assumes a single clock; the first stage is read only by the second.
module pin_sync (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  input  wire logic d_i,
  output logic      q_o
);
  // Both stages held in one packed struct
  typedef struct packed {
    logic s1;  // First stage, metastable
    logic s2;  // Second stage, safe to use
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // Shift the pin through two stages
  always_comb begin
    next_st    = st;
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  // Register with synchronous reset and clock enable
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;
endmodule : pin_sync

//--- tb/modem_model.sv
// Modem model on the far side of both serial channels.
// Assumes the bench tells it which level to put on each receive line.
module modem_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] send_i,
  output logic      [1:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bench starts the send levels at mark, so the link idles there.
  // Change levels just after the edge, as a real line driver would
  always @(posedge clk_i) begin
    rx_o <= send_i;
  end
endmodule : modem_model

//--- tb/tb_top.sv
// Self-checking bench for the modem line output block.
// Assumes the design files and the modem model are compiled first.
module tb_top;
  import uart_modem_line_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, resetn_i, strap;  // Clock, reset and mode strap
  logic [15:0] mc;               // Modem control bytes, ch1 above ch0
  logic [1:0] act, txd, send;    // Transmit controls and line levels
  logic [1:0] rx, rts_n, txo, rxd;
  logic xt;
  logic ce;                      // Clock enable to the block
  int n_fail, n_checks;
  modem_model mdm (.clk_i(clk_i), .send_i(send), .rx_o(rx));
  uart_modem_line_outputs uut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .bus_mode_strap_i(strap), .modem_ctrl_i(mc), .tx_active_i(act), .tx_data_i(txd),
    .serial_rx_in_i(rx), .rts_n_o(rts_n), .serial_tx_out_o(txo), .rx_data_o(rxd), .xt_mode_o(xt));
  // Free-running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Compare and count; an unknown never matches
  task automatic chk(input string nm, input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Let registered outputs and the synchroniser settle
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle
  // Twenty-cycle reset with the strap held at the given level; the pins
  // are checked late in reset, while any stale controls still stand
  task automatic do_reset(input logic s);
    @(posedge clk_i);
    strap <= s;
    resetn_i <= 1'b0;
    repeat (19) @(posedge clk_i);
    #1;
    chk("rts_rst", rts_n, 2'h3);
    chk("tx_rst", txo, 2'h3);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    settle();
  endtask : do_reset
  // Drive control byte pair and transmit controls, then wait
  task automatic put(input logic [15:0] m, input logic [1:0] a, input logic [1:0] d);
    @(posedge clk_i);
    mc <= m;
    act <= a;
    txd <= d;
    settle();
  endtask : put
  // Request and transmit lines driven active, then a reset over them
  task automatic t_reset();
    put(16'h0202, 2'h3, 2'h0);
    chk("rts_on", rts_n, 2'h0);
    chk("tx_space", txo, 2'h0);
    do_reset(1'b0);
    put(16'h0000, 2'h0, 2'h0);
    chk("tx_mark", txo, 2'h3);
    chk("rts_off", rts_n, 2'h3);
  endtask : t_reset
  // Each channel's request line follows its own control bit
  task automatic t_rts();
    put(16'h0002, 2'h0, 2'h0);
    chk("rts_c0", rts_n, 2'h2);
    put(16'h0200, 2'h3, 2'h1);
    chk("rts_c1", rts_n, 2'h1);
    chk("tx_data", txo, 2'h1);
    send <= 2'h1;
    settle();
    chk("rx_path", rxd, 2'h1);
    send <= 2'h2;
    settle();
    chk("rx_path2", rxd, 2'h2);
  endtask : t_rts
  // Loop mode in both bus modes, strap moved after capture
  task automatic t_loop();
    put(16'h1212, 2'h0, 2'h0);
    chk("mode_at", {1'b0, xt}, 2'h0);
    chk("loop_at", rts_n, 2'h0);
    do_reset(1'b1);
    put(16'h1212, 2'h0, 2'h0);
    chk("mode_xt", {1'b0, xt}, 2'h1);
    chk("loop_xt", rts_n, 2'h3);
    @(posedge clk_i);
    strap <= 1'b0;
    put(16'h1202, 2'h0, 2'h0);
    chk("mode_held", {1'b0, xt}, 2'h1);
    chk("loop_mix", rts_n, 2'h2);
  endtask : t_loop
  // Clock enable low freezes the pins, high lets them follow again
  task automatic t_freeze();
    @(posedge clk_i);
    ce <= 1'b0;
    mc <= 16'h0000;
    settle();
    chk("rts_frozen", rts_n, 2'h2);
    chk("mode_frozen", {1'b0, xt}, 2'h1);
    @(posedge clk_i);
    ce <= 1'b1;
    settle();
    chk("rts_thawed", rts_n, 2'h3);
  endtask : t_freeze
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    {strap, mc, act, txd, resetn_i} = '0;
    send = 2'h3;
    ce = 1'b1;
    do_reset(1'b0);
    t_reset();
    t_rts();
    t_loop();
    t_freeze();
    tally_and_finish();
  end
  // Watchdog well past the 115 or so cycles the tests need
  initial begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
endmodule : tb_top
